//--- iao_exec.sv
// execution slice with avalon-mm register access
// assumes one clock, synchronous active-high reset, master per avalon spec
`timescale 1ns/100ps
`include "iao_consts.svh"
module iao_exec
    import iao_pkg::*;
#(
    parameter int FILE_AW = 7,                  // file address width
    parameter int CYC_DIV = `IAO_CYC_DIV        // clocks per instruction cycle
) (
    input  wire logic        clk_in,            // 100 mhz clock
    input  wire logic        sys_rst_in,        // synchronous reset, high
    input  wire logic [4:0]  avs_address_in,    // byte address
    input  wire logic        avs_read_in,       // read request
    input  wire logic        avs_write_in,      // write request
    input  wire logic [31:0] avs_writedata_in,  // write data
    input  wire logic [3:0]  avs_byteenable_in, // byte lanes
    output logic      [31:0] avs_readdata_out,  // read data
    output logic             avs_waitrequest_out, // stall
    output logic      [7:0]  acc_out,           // accumulator
    output logic             zero_out           // zero flag
);

    // =================================================================
    // state
    localparam int DEPTH = 1 << FILE_AW;
    localparam int DW    = $clog2(CYC_DIV + 1);

    iao_state_t                   state_r;          // bus sequencing
    logic [4:0]                   req_addr_r;       // latched address
    logic                         req_write_r;      // latched direction
    logic [31:0]                  req_wdata_r;      // latched masked data
    logic [7:0]                   acc_r;            // accumulator
    logic                         zero_r;           // zero flag
    logic                         skip_r;           // next instruction annulled
    logic [`IAO_INSTR_WIDTH-1:0]  instr_r;          // last instruction taken
    logic [FILE_AW-1:0]           faddr_r;          // software file pointer
    logic [7:0]                   file_r [DEPTH];   // file registers
    logic [DW-1:0]                div_r;            // instruction cycle divider
    logic                         tick_r;           // instruction cycle enable
    logic [31:0]                  rdata_r;          // read data
    logic                         wait_r;           // waitrequest

    // =================================================================
    // decode of the latched request
    wire [31:0] lane_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                             {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wire        in_busy   = (state_r == IAO_ST_BUSY);
    wire        hit_instr = (req_addr_r == `IAO_OFS_INSTR);
    wire        hit_acc   = (req_addr_r == `IAO_OFS_ACC);
    wire        hit_stat  = (req_addr_r == `IAO_OFS_STATUS);
    wire        hit_faddr = (req_addr_r == `IAO_OFS_FILE_ADDR);
    wire        hit_fdata = (req_addr_r == `IAO_OFS_FILE_DATA);
    wire        instr_wr  = req_write_r & hit_instr;
    // instruction writes wait for the cycle enable, others finish at once
    wire        finish    = in_busy & (~instr_wr | tick_r);
    wire        sw_wr     = finish & req_write_r;
    wire        exec_go   = sw_wr & hit_instr;
    wire        annul     = exec_go & skip_r;           // no-operation slot
    wire        exec_run  = exec_go & ~skip_r;

    // instruction fields
    wire [7:0]          oper   = req_wdata_r[`IAO_INSTR_OPER_MSB:`IAO_INSTR_OPER_LSB];
    wire                dir    = req_wdata_r[`IAO_INSTR_DIR_BIT];
    wire iao_op_t       op     = iao_op_t'(req_wdata_r[`IAO_INSTR_OP_MSB:`IAO_INSTR_OP_LSB]);
    wire [FILE_AW-1:0]  f_idx  = oper[FILE_AW-1:0];
    wire [7:0]          f_val  = file_r[f_idx];

    // =================================================================
    // result path
    wire [7:0] alu_res;
    wire       alu_wacc;
    wire       alu_wfile;
    wire       alu_zupd;
    wire       alu_skip;

    iao_alu #(
        .W            (8)
    ) u_alu (
        .op_in        (op),
        .dir_in       (dir),
        .acc_in       (acc_r),
        .file_in      (f_val),
        .lit_in       (oper),
        .result_out   (alu_res),
        .wr_acc_out   (alu_wacc),
        .wr_file_out  (alu_wfile),
        .upd_zero_out (alu_zupd),
        .skip_out     (alu_skip)
    );

    wire alu_zero = (alu_res == 8'h00);

    // read data select, unmapped reads as zero
    wire [31:0] rd_mux = hit_instr ? {21'h000000, instr_r} :
                         hit_acc   ? {24'h000000, acc_r} :
                         hit_stat  ? {30'h00000000, skip_r, zero_r} :
                         hit_faddr ? {{(32-FILE_AW){1'b0}}, faddr_r} :
                         hit_fdata ? {24'h000000, file_r[faddr_r]} : 32'h00000000;

    // =================================================================
    // instruction cycle divider
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (div_r == DW'(CYC_DIV - 1)) begin   // wrap and pulse
            div_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + DW'(1);
            tick_r <= 1'b0;
        end
    end

    // =================================================================
    // avalon slave sequencing
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r     <= IAO_ST_IDLE;
            req_addr_r  <= 5'h00;
            req_write_r <= 1'b0;
            req_wdata_r <= 32'h00000000;
            rdata_r     <= 32'h00000000;
            wait_r      <= 1'b1;
        end else begin
            case (state_r)
                IAO_ST_IDLE: begin                      // take a request
                    wait_r <= 1'b1;
                    if (avs_read_in | avs_write_in) begin
                        req_addr_r  <= {avs_address_in[4:2], 2'b00};
                        req_write_r <= avs_write_in;
                        req_wdata_r <= avs_writedata_in & lane_mask;
                        state_r     <= IAO_ST_BUSY;
                    end
                end
                IAO_ST_BUSY: begin                      // perform, then answer
                    if (finish) begin
                        rdata_r <= req_write_r ? 32'h00000000 : rd_mux;
                        wait_r  <= 1'b0;
                        state_r <= IAO_ST_ACK;
                    end
                end
                IAO_ST_ACK: begin                       // one cycle of answer
                    wait_r  <= 1'b1;
                    state_r <= IAO_ST_IDLE;
                end
                default: begin
                    wait_r  <= 1'b1;
                    state_r <= IAO_ST_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // accumulator, flags and instruction capture
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            acc_r   <= `IAO_RST_ACC;
            zero_r  <= 1'b0;
            skip_r  <= 1'b0;
            instr_r <= `IAO_RST_INSTR;
            faddr_r <= '0;
        end else begin
            if (exec_go) begin                          // annulled slot still recorded
                instr_r <= req_wdata_r[`IAO_INSTR_WIDTH-1:0];
            end
            if (annul) begin                            // no-operation replaces it
                skip_r <= 1'b0;
            end else if (exec_run) begin
                skip_r <= alu_skip;
                if (alu_wacc) begin
                    acc_r <= alu_res;
                end
                if (alu_zupd) begin
                    zero_r <= alu_zero;
                end
            end else if (sw_wr & hit_acc) begin         // software load
                acc_r <= req_wdata_r[7:0];
            end else if (sw_wr & hit_stat) begin        // zero flag writable
                zero_r <= req_wdata_r[`IAO_STAT_ZERO_BIT];
            end
            if (sw_wr & hit_faddr) begin
                faddr_r <= req_wdata_r[FILE_AW-1:0];
            end
        end
    end

    // =================================================================
    // file registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                file_r[i] <= `IAO_RST_FILE;
            end
        end else if (exec_run & alu_wfile) begin        // write back
            file_r[f_idx] <= alu_res;
        end else if (sw_wr & hit_fdata) begin           // software store
            file_r[faddr_r] <= req_wdata_r[7:0];
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign acc_out             = acc_r;
    assign zero_out            = zero_r;

    // =================================================================
    // checks
    wire is_inc   = exec_run & (op == IAO_OP_INCREMENT_FILE);
    wire is_incsz = exec_run & (op == IAO_OP_INCREMENT_FILE_SKIP_ZERO);
    wire is_orl   = exec_run & (op == IAO_OP_OR_LITERAL_INTO_ACC);
    wire is_orf   = exec_run & (op == IAO_OP_OR_ACC_WITH_FILE);
    wire [7:0] inc_chk = f_val + 8'h01;
    wire [7:0] orf_chk = acc_r | f_val;
    wire [7:0] orl_chk = acc_r | oper;

    a_inc_to_acc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_inc & ~dir |=> acc_r == $past(inc_chk))
        else $error("increment to accumulator wrong");
    a_inc_to_file: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_inc & dir |=> (file_r[f_idx] == $past(inc_chk)) && $stable(acc_r))
        else $error("increment to file wrong");
    a_skip_arms: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_incsz |=> skip_r == ($past(inc_chk) == 8'h00))
        else $error("skip flag not tied to zero result");
    a_skip_annuls: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        annul |=> $stable(acc_r) && $stable(zero_r) && !skip_r)
        else $error("annulled slot changed state");
    a_skip_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_incsz |=> $stable(zero_r))
        else $error("skip form changed zero flag");
    a_orl_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_orl |=> acc_r == $past(orl_chk) && zero_r == ($past(orl_chk) == 8'h00))
        else $error("or literal result wrong");
    a_orf_to_file: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_orf & dir |=> file_r[f_idx] == $past(orf_chk) && $stable(acc_r))
        else $error("or to file wrong");
    a_orf_to_acc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_orf & ~dir |=> acc_r == $past(orf_chk))
        else $error("or to accumulator wrong");
    a_zero_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (is_inc | is_orf) |=> zero_r == ($past(is_inc ? inc_chk : orf_chk) == 8'h00))
        else $error("zero flag mismatch");

endmodule // iao_exec

//--- iao_consts.svh
// constants for the increment / inclusive-or execution slice
// assumes a 32-bit avalon-mm slave with byte addresses
// What this block does
// - increment file, destination chosen by direction bit
// - increment-skip: zero result annuls next instruction
// - increment-skip never touches the zero flag
// - or literal into accumulator, zero flag updated
// - or accumulator with file, direction picks destination
`ifndef IAO_CONSTS_SVH
`define IAO_CONSTS_SVH

// =====================================================================
// register byte offsets
`define IAO_OFS_INSTR      5'h00
`define IAO_OFS_ACC        5'h04
`define IAO_OFS_STATUS     5'h08
`define IAO_OFS_FILE_ADDR  5'h0c
`define IAO_OFS_FILE_DATA  5'h10

// =====================================================================
// instruction word field positions
`define IAO_INSTR_OPER_LSB 0
`define IAO_INSTR_OPER_MSB 7
`define IAO_INSTR_DIR_BIT  8
`define IAO_INSTR_OP_LSB   9
`define IAO_INSTR_OP_MSB   10
`define IAO_INSTR_WIDTH    11

// status field positions
`define IAO_STAT_ZERO_BIT  0
`define IAO_STAT_SKIP_BIT  1

// =====================================================================
// reset values and timing
`define IAO_RST_ACC        8'h00
`define IAO_RST_INSTR      11'h000
`define IAO_RST_FILE       8'h00
`define IAO_CYC_DIV        4

`endif

//--- iao_pkg.sv
// types shared by the execution slice
// assumes iao_consts.svh for all numbers
package iao_pkg;

    // =================================================================
    // operation select of the instruction word
    typedef enum logic [1:0] {
        IAO_OP_INCREMENT_FILE           = 2'b00,
        IAO_OP_INCREMENT_FILE_SKIP_ZERO = 2'b01,
        IAO_OP_OR_LITERAL_INTO_ACC      = 2'b10,
        IAO_OP_OR_ACC_WITH_FILE         = 2'b11
    } iao_op_t;

    // bus slave sequencing
    typedef enum logic [1:0] {
        IAO_ST_IDLE = 2'b00,
        IAO_ST_BUSY = 2'b01,
        IAO_ST_ACK  = 2'b10
    } iao_state_t;

endpackage

//--- iao_alu.sv
// combinational result path of the four operations
// assumes operands are stable for the whole evaluation cycle
`timescale 1ns/100ps
module iao_alu
    import iao_pkg::*;
#(
    parameter int W = 8                         // data width
) (
    input  wire iao_op_t      op_in,            // operation select
    input  wire logic         dir_in,           // 0 accumulator, 1 file
    input  wire logic [W-1:0] acc_in,           // accumulator value
    input  wire logic [W-1:0] file_in,          // addressed file value
    input  wire logic [W-1:0] lit_in,           // immediate literal
    output logic      [W-1:0] result_out,       // operation result
    output logic              wr_acc_out,       // result goes to accumulator
    output logic              wr_file_out,      // result goes to file
    output logic              upd_zero_out,     // zero flag is affected
    output logic              skip_out          // annul next instruction
);

    // =================================================================
    // operation decode
    wire is_inc   = (op_in == IAO_OP_INCREMENT_FILE);
    wire is_incsz = (op_in == IAO_OP_INCREMENT_FILE_SKIP_ZERO);
    wire is_orl   = (op_in == IAO_OP_OR_LITERAL_INTO_ACC);
    wire is_orf   = (op_in == IAO_OP_OR_ACC_WITH_FILE);

    wire [W-1:0] inc_val = file_in + W'(1);       // wraps at all ones
    wire [W-1:0] orl_val = acc_in | lit_in;
    wire [W-1:0] orf_val = acc_in | file_in;

    // result select
    assign result_out   = (is_inc | is_incsz) ? inc_val : (is_orl ? orl_val : orf_val);
    // literal form always lands in accumulator
    assign wr_acc_out   = is_orl | ~dir_in;
    assign wr_file_out  = (is_inc | is_incsz | is_orf) & dir_in;
    // skip form leaves the zero flag alone
    assign upd_zero_out = ~is_incsz;
    assign skip_out     = is_incsz & (inc_val == '0);

endmodule // iao_alu

//--- tb_iao_exec.sv
// self-checking bench for the increment / inclusive-or execution slice
// assumes iao_exec with its avalon-mm slave and the shared consts header
`timescale 1ns/100ps
`include "iao_consts.svh"
module tb_iao_exec
    import iao_pkg::*;
();

    // =================================================================
    // stimulus and observation signals
    logic        clk_in;            // bench clock
    logic        sys_rst_in;        // synchronous reset
    logic [4:0]  avs_address_in;    // byte address
    logic        avs_read_in;       // read request
    logic        avs_write_in;      // write request
    logic [31:0] avs_writedata_in;  // write data
    logic [3:0]  avs_byteenable_in; // all lanes on
    logic [31:0] avs_readdata_out;  // read data
    logic        avs_waitrequest_out; // stall
    logic [7:0]  acc_out;           // accumulator
    logic        zero_out;          // zero flag
    int          fail_count;        // mismatches
    int          n_checks;          // comparisons
    int          cyc;               // timeout counter

    iao_exec uut (
        .clk_in              (clk_in),
        .sys_rst_in          (sys_rst_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .acc_out             (acc_out),
        .zero_out            (zero_out)
    );

    // =================================================================
    // clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // cut a hang short after a generous cycle ceiling
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // =================================================================
    // tasks
    // counts and verdict, then stop
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus access, held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [4:0] a,
                            input logic [31:0] d, output logic [31:0] q);
        avs_address_in   <= a;
        avs_write_in     <= wr;
        avs_read_in      <= ~wr;
        avs_writedata_in <= d;
        @(posedge clk_in);
        // only the bench-wide cycle ceiling ends a hang here
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge clk_in);
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        @(posedge clk_in);
    endtask

    // register write
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    // register read and compare
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // run one instruction word
    task automatic exec(input iao_op_t op, input logic d, input logic [7:0] k);
        wr(`IAO_OFS_INSTR, {21'h000000, op, d, k});
    endtask

    // load one file register
    task automatic setf(input logic [7:0] i, input logic [7:0] v);
        wr(`IAO_OFS_FILE_ADDR, {24'h000000, i});
        wr(`IAO_OFS_FILE_DATA, {24'h000000, v});
    endtask

    // =================================================================
    // main sequence
    initial begin
        fail_count = 0;
        n_checks = 0;
        cyc = 0;
        sys_rst_in = 1'b1;
        avs_address_in = 5'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hf;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        // reset state, unmapped place
        check(32'(acc_out), 32'h0);
        check(32'(zero_out), 32'h0);
        rd_chk(`IAO_OFS_STATUS, 32'h0);
        wr(5'h14, 32'hff);
        rd_chk(5'h14, 32'h0);
        rd_chk(`IAO_OFS_ACC, 32'h0);
        $display("test reset done");
        // increment to either destination, wrap to zero
        setf(8'h05, 8'h41);
        exec(IAO_OP_INCREMENT_FILE, 1'b0, 8'h05);
        check(32'(acc_out), 32'h42);
        check(32'(zero_out), 32'h0);
        rd_chk(`IAO_OFS_FILE_DATA, 32'h41);
        exec(IAO_OP_INCREMENT_FILE, 1'b1, 8'h05);
        rd_chk(`IAO_OFS_FILE_DATA, 32'h42);
        setf(8'h05, 8'hff);
        exec(IAO_OP_INCREMENT_FILE, 1'b1, 8'h05);
        rd_chk(`IAO_OFS_FILE_DATA, 32'h0);
        check(32'(zero_out), 32'h1);
        check(32'(acc_out), 32'h42);
        $display("test increment done");
        // or literal, zero and nonzero results
        wr(`IAO_OFS_ACC, 32'h0);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h00);
        check(32'(acc_out), 32'h0);
        check(32'(zero_out), 32'h1);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h5a);
        check(32'(acc_out), 32'h5a);
        check(32'(zero_out), 32'h0);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b1, 8'h81);
        check(32'(acc_out), 32'hdb);
        $display("test or literal done");
        // or with file, both destinations
        setf(8'h09, 8'hf0);
        wr(`IAO_OFS_ACC, 32'h0f);
        exec(IAO_OP_OR_ACC_WITH_FILE, 1'b0, 8'h09);
        check(32'(acc_out), 32'hff);
        wr(`IAO_OFS_ACC, 32'h0c);
        exec(IAO_OP_OR_ACC_WITH_FILE, 1'b1, 8'h09);
        rd_chk(`IAO_OFS_FILE_DATA, 32'hfc);
        check(32'(acc_out), 32'h0c);
        setf(8'h09, 8'h00);
        wr(`IAO_OFS_ACC, 32'h0);
        exec(IAO_OP_OR_ACC_WITH_FILE, 1'b1, 8'h09);
        check(32'(zero_out), 32'h1);
        $display("test or file done");
        // skip on zero with zero flag set, next word annulled
        setf(8'h03, 8'hff);
        exec(IAO_OP_INCREMENT_FILE_SKIP_ZERO, 1'b1, 8'h03);
        rd_chk(`IAO_OFS_FILE_DATA, 32'h0);
        check(32'(zero_out), 32'h1);
        rd_chk(`IAO_OFS_STATUS, 32'h3);
        wr(`IAO_OFS_ACC, 32'h10);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h01);
        check(32'(acc_out), 32'h10);
        rd_chk(`IAO_OFS_INSTR, {21'h000000, IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h01});
        rd_chk(`IAO_OFS_STATUS, 32'h1);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h01);
        check(32'(acc_out), 32'h11);
        // nonzero result: no skip, flag untouched
        setf(8'h03, 8'h10);
        exec(IAO_OP_INCREMENT_FILE_SKIP_ZERO, 1'b0, 8'h03);
        check(32'(acc_out), 32'h11);
        check(32'(zero_out), 32'h0);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h20);
        check(32'(acc_out), 32'h31);
        // zero result with flag clear keeps it clear
        setf(8'h03, 8'hff);
        exec(IAO_OP_INCREMENT_FILE_SKIP_ZERO, 1'b0, 8'h03);
        check(32'(acc_out), 32'h0);
        check(32'(zero_out), 32'h0);
        exec(IAO_OP_OR_LITERAL_INTO_ACC, 1'b0, 8'h07);
        check(32'(acc_out), 32'h0);
        $display("test skip done");
        report_and_stop();
    end

endmodule // tb_iao_exec
